// >>> hdl/acc_bit_ops_pkg.sv
// Purpose: shared constants and opcode set for the accumulator bit-operation unit
// Assumes: 32-bit accumulator, opcodes issued by an external sequencer
// Notes:   one package for the single design file
package acc_bit_ops_pkg;
  localparam int unsigned ACC_WIDTH     = 32;
  localparam int unsigned COUNT_WIDTH   = 6;
  localparam int unsigned INDEX_WIDTH   = 5;
  localparam logic [31:0] ACC_RESET     = 32'h0000_0000;
  localparam logic [5:0]  COUNT_MAX     = 6'h20;
  localparam logic [31:0] ENC_MSB_VALUE = 32'h0000_001f;

  typedef enum logic [3:0] {
    nop_op,
    load_op,
    shift_left_op,
    shift_right_op,
    rotate_left_op,
    rotate_right_op,
    encode_op,
    one_hot_decode_op,
    bcd_to_binary_op
  } op_t;
endpackage : acc_bit_ops_pkg

// >>> hdl/accumulator_bit_ops_unit.sv
// Purpose: 32-bit accumulator executing shift, rotate, encode, decode and bcd conversion
// Assumes: one instruction per cycle; counts outside 1..32 are flagged, not trusted
// Notes:   result and flag are registered one edge after op_valid
// Function
// - shift left fills zeros, drops top
// - shift right fills zeros, drops bottom
// - rotate left wraps top bits to bottom
// - rotate right wraps bottom bits to top
// - encode gives index of set bit
// - encode of zero or one gives zero
// - multiple bits: lowest encoded, flag set
// - encode of zero sets range flag
// - oversize operand sets range flag
// - flag held until affecting instruction recomputes
// - decode sets bit at five-bit index
// - decode input over 31 divided down
// - bcd converted to binary equivalent
`timescale 1ns/10ps
`default_nettype none

module accumulator_bit_ops_unit
  import acc_bit_ops_pkg::*;
#(
  parameter int unsigned WIDTH = ACC_WIDTH
) (
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  input  wire logic                   op_valid,
  input  wire op_t                    opcode,
  input  wire logic [COUNT_WIDTH-1:0] count,
  input  wire logic [WIDTH-1:0]       load_value,
  output var  logic [WIDTH-1:0]       acc,
  output var  logic                   operand_range_flag,
  output var  logic                   done
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check: shifters, encoder and bcd weights are built for 32 bits only
  if (WIDTH != 32) begin : g_width_check
    $error("accumulator width must be 32");
  end

  // next values and shared helper terms
  logic [WIDTH-1:0] next_acc;
  logic             next_flag;
  logic             next_done;
  logic [WIDTH-1:0] enc_value;
  logic             enc_multi;
  logic [WIDTH-1:0] bcd_value;
  logic [WIDTH-1:0] rot_src;
  logic [5:0]       amt;
  logic             count_bad;
  logic [4:0]       dec_index;

  ////////////////////////////////////////////////////////////////////////
  // encoder: scan downward so the lowest set bit wins
  always_comb begin
    enc_value = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (acc[i]) enc_value = 32'(i);
    end
    enc_multi = (acc & (acc - 32'h0000_0001)) != '0;
  end

  // bcd digits weighted by powers of ten; eight nibbles cover 99999999
  always_comb begin
    bcd_value = '0;
    for (int d = 7; d >= 0; d--) begin
      bcd_value = 32'(bcd_value * 32'd10 + 32'(acc[d*4 +: 4]));
    end
  end

  // repeated divide by 32 leaves the top nonzero five-bit group
  always_comb begin
    dec_index = acc[4:0];
    for (int g = 1; g < 7; g++) begin
      if ((acc >> (5 * g)) != '0) dec_index = 5'(acc >> (5 * g));
    end
  end

  // count outside 1..32 is clamped and flagged rather than trusted
  // a memory-sourced count can hold anything, so the unit cannot rely on the issuer
  always_comb begin
    count_bad = (count == 6'h00) || (count > COUNT_MAX);
    amt       = count_bad ? COUNT_MAX : count;
    rot_src   = acc;
  end

  ////////////////////////////////////////////////////////////////////////
  // next accumulator, flag and completion strobe
  always_comb begin
    next_acc  = acc;
    next_flag = operand_range_flag;
    next_done = 1'b0;
    if (op_valid) begin
      next_done = 1'b1;
      unique case (opcode)
        nop_op: begin
          next_done = 1'b0;
        end
        load_op: begin
          next_acc = load_value;
        end
        shift_left_op: begin
          next_acc  = (amt >= COUNT_MAX) ? '0 : (acc << amt);
          next_flag = count_bad;
        end
        shift_right_op: begin
          next_acc  = (amt >= COUNT_MAX) ? '0 : (acc >> amt);
          next_flag = count_bad;
        end
        rotate_left_op: begin
          next_acc  = 32'({rot_src, rot_src} >> (COUNT_MAX - amt));
          next_flag = count_bad;
        end
        rotate_right_op: begin
          next_acc  = 32'({rot_src, rot_src} >> amt);
          next_flag = count_bad;
        end
        encode_op: begin
          // zero and one both give zero; only the flag tells them apart
          next_acc  = (acc <= 32'h0000_0001) ? '0 : enc_value;
          next_flag = (acc == '0) || enc_multi;
        end
        one_hot_decode_op: begin
          next_acc = '0;
          next_acc[dec_index] = 1'b1;
        end
        bcd_to_binary_op: begin
          next_acc = bcd_value;
        end
        default: begin
          next_done = 1'b0;
        end
      endcase
    end
  end

  // registers only; every output comes straight from these flops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc                <= ACC_RESET;
      operand_range_flag <= 1'b0;
      done               <= 1'b0;
    end else begin
      acc                <= next_acc;
      operand_range_flag <= next_flag;
      done               <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_shl_result: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == shift_left_op && !count_bad |=> acc == $past(acc) << $past(count))
    else $error("shift left result wrong");
  a_shr_result: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == shift_right_op && !count_bad |=> acc == $past(acc) >> $past(count))
    else $error("shift right result wrong");
  a_rol_result: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == rotate_left_op && count == 6'h01 |=> acc == {$past(acc[30:0]), $past(acc[31])})
    else $error("rotate left result wrong");
  a_ror_result: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == rotate_right_op && count == 6'h01 |=> acc == {$past(acc[0]), $past(acc[31:1])})
    else $error("rotate right result wrong");
  a_enc_msb: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == encode_op && acc == 32'h8000_0000 |=> acc == ENC_MSB_VALUE && !operand_range_flag)
    else $error("encode of top bit wrong");
  a_enc_low: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == encode_op && acc <= 32'h0000_0001 |=> acc == '0)
    else $error("encode of zero or one not zero");
  a_enc_flag: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == encode_op && (acc == '0 || $countones(acc) > 1) |=> operand_range_flag)
    else $error("encode range flag missing");
  a_count_flag: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode inside {shift_left_op, shift_right_op, rotate_left_op, rotate_right_op}
      && (count == 6'h00 || count > COUNT_MAX) |=> operand_range_flag)
    else $error("bad count not flagged");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && (opcode == one_hot_decode_op || opcode == bcd_to_binary_op
      || opcode == load_op || opcode == nop_op) |=> $stable(operand_range_flag))
    else $error("flag changed by unrelated op");
  a_dec_onehot: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == one_hot_decode_op && acc < 32'h0000_0020 |=> acc == 32'h1 << $past(acc[4:0]))
    else $error("decode not one-hot at index");
  a_done_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode != nop_op |=> done ##1 (done == $past(op_valid && opcode != nop_op)))
    else $error("done strobe wrong");

  ////////////////////////////////////////////////////////////////////////
  // full-count corners: the shift checks above already catch 32 folded into 0; the rotate checks above do not
  a_shl_full: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == shift_left_op && count == COUNT_MAX |=> acc == '0)
    else $error("shift left by full width not zero");
  a_shr_full: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == shift_right_op && count == COUNT_MAX |=> acc == '0)
    else $error("shift right by full width not zero");
  a_rot_full: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && (opcode == rotate_left_op || opcode == rotate_right_op) && count == COUNT_MAX |=> acc == $past(acc))
    else $error("full rotate changed the accumulator");
  // encode: index of a lone bit, and bit zero winning over higher bits
  a_enc_index: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == encode_op && $onehot(acc) |=> (32'h1 << acc[4:0]) == $past(acc) && acc < 32'h0000_0020)
    else $error("encode index wrong");
  a_enc_lsb: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == encode_op && acc[0] |=> acc == '0 && operand_range_flag == ($past(acc) != 32'h0000_0001))
    else $error("encode lowest bit wrong");
  // decode and conversion
  a_dec_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == one_hot_decode_op && acc >= 32'h0000_0020 && acc < 32'h0000_0400
      |=> acc == (32'h1 << $past(acc[9:5])))
    else $error("decode of wide value wrong");
  a_dec_strict: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == one_hot_decode_op |=> $onehot(acc))
    else $error("decode result not one-hot");
  a_bcd_digit: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == bcd_to_binary_op && acc < 32'h0000_000a |=> acc == $past(acc))
    else $error("single digit conversion wrong");
  // flag recompute and strobe
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode inside {shift_left_op, shift_right_op, rotate_left_op, rotate_right_op}
      && count != 6'h00 && count <= COUNT_MAX |=> !operand_range_flag)
    else $error("legal count left the flag set");
  a_done_nop: assert property (@(posedge ref_clk) disable iff (srst)
    op_valid && opcode == nop_op |=> !done)
    else $error("done raised by empty instruction");

endmodule : accumulator_bit_ops_unit

`default_nettype wire

// >>> sim/instr_issuer.sv
// Purpose: stand-in for the instruction sequencer on the far side
// Assumes: bench raises req for one cycle per instruction
// Notes:   immediate counts are folded into 1..32; memory-sourced counts pass untouched
`timescale 1ns/10ps
`default_nettype none
module instr_issuer
  import acc_bit_ops_pkg::*;
(
  input  wire logic                   req,
  input  wire logic                   req_mem,
  input  wire op_t                    req_op,
  input  wire logic [COUNT_WIDTH-1:0] req_count,
  input  wire logic [ACC_WIDTH-1:0]   req_value,
  output var  logic                   op_valid,
  output var  op_t                    opcode,
  output var  logic [COUNT_WIDTH-1:0] count,
  output var  logic [ACC_WIDTH-1:0]   load_value
);
  // only immediate counts are forced legal; memory-sourced counts leave the sequencer as fetched
  always_comb begin
    op_valid   = req;
    opcode     = req_op;
    load_value = req_value;
    // a count fetched from data memory is whatever the memory holds
    count      = (!req_mem && (req_count == 6'h00 || req_count > COUNT_MAX)) ? COUNT_MAX : req_count;
  end
endmodule : instr_issuer
`default_nettype wire

// >>> sim/test_accumulator_bit_ops_unit.sv
// Purpose: self-checking bench for the accumulator bit-operation unit
// Assumes: fixed seed, one instruction every second cycle
// Notes:   expectations come from a local reference function
`timescale 1ns/10ps
`default_nettype none
module test_accumulator_bit_ops_unit
  import acc_bit_ops_pkg::*;
;
  logic ref_clk = 1'b0, srst = 1'b1, req = 1'b0, op_valid, flag, done, f;
  logic req_m = 1'b0, mem_src = 1'b0;
  op_t req_op = nop_op, opcode;
  logic [5:0] req_c = 6'h01, count;
  logic [31:0] req_v = 32'h0, load_value, acc, a;
  int seed = 96583, compares = 0, miscompares = 0;
  always #2 ref_clk = ~ref_clk;
  instr_issuer i_instr_issuer (.req(req), .req_op(req_op), .req_count(req_c), .req_value(req_v),
    .op_valid(op_valid), .opcode(opcode), .count(count), .load_value(load_value), .req_mem(req_m));
  accumulator_bit_ops_unit i_accumulator_bit_ops_unit (.ref_clk(ref_clk), .srst(srst), .op_valid(op_valid),
    .opcode(opcode), .count(count), .load_value(load_value), .acc(acc), .operand_range_flag(flag), .done(done));
  ////////////////////////////////////////////////////////////////////////////
  // reference result {flag, acc}; flag passes through untouched ops
  function automatic logic [32:0] model(op_t op, logic [31:0] x, logic fl, logic [5:0] c, logic [31:0] v);
    logic [31:0] r;
    logic [63:0] d;
    logic        bad;
    logic [5:0]  cc;
    r = x;
    // a count outside 1..32 acts as 32 and raises the flag
    bad = (c == 6'h00) || (c > 6'h20);
    cc = bad ? 6'h20 : c;
    case (op)
      load_op:           r = v;
      shift_left_op:     begin r = x << cc; fl = bad; end
      shift_right_op:    begin r = x >> cc; fl = bad; end
      rotate_left_op:    begin d = {x, x} << cc; r = d[63:32]; fl = bad; end
      rotate_right_op:   begin d = {x, x} >> cc; r = d[31:0]; fl = bad; end
      encode_op:         begin
        r = 32'h0;
        fl = (x == 32'h0) || ((x & (x - 32'h1)) != 32'h0);
        for (int i = 31; i >= 0; i--) if (x[i]) r = i;
      end
      one_hot_decode_op: begin d = {32'h0, x}; while (d > 64'h1f) d = d / 64'h20; r = 32'h1 << d[4:0]; end
      bcd_to_binary_op:  begin r = 32'h0; for (int i = 7; i >= 0; i--) r = r * 10 + x[4*i+:4]; end
      default:           r = x;
    endcase
    return {fl, r};
  endfunction : model
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one instruction, result looked at in the cycle after it is taken
  task automatic issue(input op_t op, input logic [5:0] c, input logic [31:0] v);
    logic [32:0] e;
    e = model(op, a, f, (!mem_src && (c == 6'h00 || c > 6'h20)) ? 6'h20 : c, v);
    @(posedge ref_clk);
    req <= 1'b1; req_op <= op; req_c <= c; req_v <= v; req_m <= mem_src;
    @(posedge ref_clk);
    req <= 1'b0;
    #1;
    check({31'h0, done}, {31'h0, op != nop_op});
    check(acc, e[31:0]);
    check({31'h0, flag}, {31'h0, e[32]});
    {f, a} = e;
  endtask : issue
  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    a = 32'h0;
    f = 1'b0;
    #1;
    check(acc, 32'h0);
    check({31'h0, flag}, 32'h0);
    check({31'h0, done}, 32'h0);
    // corners: encode edges, full-width counts, wrapped decode, largest bcd
    issue(load_op, 6'h01, 32'h8000_0000); issue(encode_op, 6'h01, 32'h0);
    issue(load_op, 6'h01, 32'h0); issue(encode_op, 6'h01, 32'h0);
    issue(one_hot_decode_op, 6'h01, 32'h0);
    issue(load_op, 6'h01, 32'h1); issue(encode_op, 6'h01, 32'h0);
    issue(load_op, 6'h01, 32'h0000_0a50); issue(encode_op, 6'h01, 32'h0);
    issue(load_op, 6'h01, 32'hc000_0003); issue(shift_left_op, 6'h20, 32'h0);
    issue(load_op, 6'h01, 32'hc000_0003); issue(rotate_right_op, 6'h20, 32'h0);
    issue(load_op, 6'h01, 32'h0000_0400); issue(one_hot_decode_op, 6'h01, 32'h0);
    issue(load_op, 6'h01, 32'h9999_9999); issue(bcd_to_binary_op, 6'h01, 32'h0);
    issue(load_op, 6'h01, 32'h0000_0123); issue(one_hot_decode_op, 6'h01, 32'h0);
    issue(nop_op, 6'h01, 32'hffff_ffff);
    // memory-sourced counts outside 1..32 reach the unit and must raise the flag
    mem_src = 1'b1;
    issue(load_op, 6'h01, 32'h0000_00f0); issue(shift_left_op, 6'h00, 32'h0);
    issue(shift_right_op, 6'h04, 32'h0);
    issue(load_op, 6'h01, 32'h1234_5678); issue(rotate_left_op, 6'h2a, 32'h0);
    mem_src = 1'b0;
    $display("corner tests done");
    // reset in mid-run with the flag set and the accumulator loaded
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    check(acc, 32'h0);
    check({31'h0, flag}, 32'h0);
    check({31'h0, done}, 32'h0);
    a = 32'h0;
    f = 1'b0;
    $display("reset test done");
    for (int n = 0; n < 300; n++) begin
      mem_src = 1'($random(seed));
      issue(op_t'(4'($unsigned($random(seed)) % 9)), 6'($unsigned($random(seed)) % 34),
        (n % 3 == 0) ? 32'h1 << ($unsigned($random(seed)) % 32) : $random(seed));
    end
    mem_src = 1'b0;
    $display("random tests done");
    final_report();
  end
endmodule : test_accumulator_bit_ops_unit
`default_nettype wire
